// [bench/fcd_flash_model.sv]
`timescale 1ns/10ps
// behavioural flash device behind the pins
module fcd_flash_model
    import fcd_pkg::*;
#(
    parameter int          BUSY_NS = 1000,    // algorithm run time
    parameter logic [15:0] ID_MFR  = 16'h00a5, // arbitrary value
    parameter logic [15:0] ID_DEV  = 16'h003c  // arbitrary value
) (
    input  wire logic        mclk_i,    // bench clock
    input  wire logic        ce_b_i,    // chip enable, low
    input  wire logic        we_b_i,    // write strobe, low
    input  wire logic        oe_b_i,    // output enable, low
    input  wire logic [23:0] addr_i,    // address
    input  wire logic [15:0] dq_i,      // data wire level
    input  wire logic        program_enable_supply_hi_i, // supply at high level
    output logic [15:0]      dq_o,      // data driven back
    output logic [7:0]       bad_o,     // reserved codes seen
    output logic [7:0]       abort_o    // buffer aborts seen
);
    localparam int BW = 16;                  // word bits inside a block
    logic [15:0]  mem [int];                 // written words, others erased
    logic [15:0]  bq [$];                    // buffer words
    int           bqa [$];                   // buffer addresses
    logic [255:0] lock = '0;                 // block lock bits
    logic [7:0]   mode = FCD_CMD_READ_ARRAY; // array read at power-up
    logic [7:0]   err = '0, st = '0, s, c, n; // errors, pending step, decode
    logic         busy = 1'b0, susp = 1'b0, go, run;
    logic [23:0]  la;                        // address seen in the cycle
    logic [15:0]  ld, lq = '0;               // data seen, last wire value
    bit           act;                       // write cycle, two-state
    assign act = !ce_b_i && !we_b_i;
    initial {bad_o, abort_o} = '0;
    // sample write pins; keep last wire level
    always @(posedge mclk_i) begin
        if (act) begin
            la = addr_i;
            ld = dq_i;
        end
        lq <= dq_o;
    end
    // decode when the strobe or chip enable ends the cycle
    always @(negedge act) begin
        c = ld[7:0]; // upper byte ignored
        go = program_enable_supply_hi_i && !lock[la[23:BW]];
        run = 1'b0;
        s = st;
        st = 8'h00;
        case (s)
            8'h00: case (c)
                FCD_CMD_READ_ARRAY: if (!busy || susp) mode = c;
                FCD_CMD_READ_ID, FCD_CMD_READ_QUERY, FCD_CMD_READ_STAT: mode = c;
                FCD_CMD_CLR_STAT: err = '0;
                FCD_CMD_PROG_A, FCD_CMD_PROG_B, FCD_CMD_ERASE, FCD_CMD_LOCK_SETUP: st = c;
                FCD_CMD_BUF_PROG: begin // buffer free shown next
                    mode = c;
                    st = c;
                end
                FCD_CMD_SUSPEND: susp = busy;
                FCD_CMD_CONFIRM: susp = 1'b0; // resume
                default: bad_o++; // reserved, mode kept
            endcase
            FCD_CMD_PROG_A, FCD_CMD_PROG_B: begin // either setup code
                if (go) mem[la] = ld;
                run = 1'b1;
            end
            FCD_CMD_ERASE: if (c == FCD_CMD_CONFIRM) begin // only on confirm
                if (go) foreach (mem[k]) if (k[23:BW] == la[23:BW]) mem[k] = 16'hffff;
                run = 1'b1;
            end
            FCD_CMD_LOCK_SETUP: begin
                if (c == FCD_CMD_LOCK_SET) lock[la[23:BW]] = 1'b1; // set lock bit of the addressed block
                if (c == FCD_CMD_CONFIRM) lock = '0;
                mode = FCD_CMD_READ_STAT;
            end
            FCD_CMD_BUF_PROG: begin // count argument
                n = ld[7:0];
                bq.delete();
                bqa.delete();
                st = 8'h01;
            end
            8'h01: begin // count plus one words
                bq.push_back(ld);
                bqa.push_back(int'(la));
                st = (bq.size() > n) ? 8'h02 : 8'h01;
            end
            default: if (c == FCD_CMD_CONFIRM) begin
                if (go) foreach (bq[i]) mem[bqa[i]] = bq[i];
                run = 1'b1;
            end else begin
                abort_o++;
            end
        endcase
        if (run) begin
            mode = FCD_CMD_READ_STAT;
            if (!go) err = err | (program_enable_supply_hi_i ? 8'h12 : 8'h18);
            busy = 1'b1;
            busy <= #BUSY_NS 1'b0;
        end
    end
    // read data for the selected mode
    function automatic logic [15:0] rd(input logic [23:0] a, input logic [7:0] m, input logic bz);
        case (m)
            FCD_CMD_READ_ID: case (a[1:0])
                2'd0: return ID_MFR;
                2'd1: return ID_DEV;
                2'd2: return {15'h0000, lock[a[23:BW]]};
                default: return 16'h0000;
            endcase
            FCD_CMD_READ_QUERY: return (a[7:0] == 8'h10) ? 16'h0051 : 16'h0000;
            FCD_CMD_READ_STAT: return bz ? {~lq[15:8], 1'b0, ~lq[6:0]} : {9'h001, err[6:0]};
            FCD_CMD_BUF_PROG: return 16'h0080;
            default: return mem.exists(a) ? mem[a] : 16'hffff;
        endcase
    endfunction
    assign dq_o = (!ce_b_i && !oe_b_i) ? rd(addr_i, mode, busy) : ~lq;
endmodule

// [bench/fcd_host_assertions.sv]
`timescale 1ns/10ps
// host pin protocol checks
module fcd_host_chk
    import fcd_pkg::*;
#(
    parameter int AW = 24  // address width
) (
    input wire logic          mclk_i,     // clock
    input wire logic          rst_b_i,    // reset, low
    input wire logic          op_valid_i, // request
    input wire logic          op_ready_o, // ready
    input wire logic          done_o,     // done
    input wire logic          ce_b_o,     // chip enable
    input wire logic          we_b_o,     // write strobe
    input wire logic          oe_b_o,     // output enable
    input wire logic [AW-1:0] faddr_o,    // address
    input wire logic [15:0]   fdq_o,      // data out
    input wire logic          fdq_oe_o    // data enable
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // idle after reset
    a_reset_idle: assert property ($rose(rst_b_i) |-> ce_b_o && we_b_o && oe_b_o)
        else $error("pins not idle after reset");
    a_strobe_excl: assert property (!(!we_b_o && !oe_b_o))
        else $error("we and oe low together");
    a_write_drive: assert property (!we_b_o |-> !ce_b_o && fdq_oe_o)
        else $error("write without ce or data");
    a_read_float: assert property (!oe_b_o |-> !ce_b_o && !fdq_oe_o)
        else $error("data driven in read");
    a_we_width: assert property ($fell(we_b_o) |=> !we_b_o ##1 we_b_o)
        else $error("write strobe width wrong");
    // held while strobe low
    a_wr_hold: assert property (!we_b_o && !$past(we_b_o) |-> $stable(faddr_o) && $stable(fdq_o))
        else $error("write hold broken");
    a_we_recover: assert property ($rose(we_b_o) |=> we_b_o)
        else $error("no recovery cycle after write");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done too long");
    a_op_to_bus: assert property (op_valid_i && op_ready_o |-> ##[1:40] !ce_b_o)
        else $error("no bus cycle");
    c_write: cover property ($rose(we_b_o));
    c_read: cover property ($rose(oe_b_o));
    c_done: cover property (done_o);
endmodule
bind fcd_host fcd_host_chk #(.AW(AW)) u_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_ready_o(op_ready_o),
    .done_o(done_o), .ce_b_o(ce_b_o), .we_b_o(we_b_o), .oe_b_o(oe_b_o), .faddr_o(faddr_o),
    .fdq_o(fdq_o), .fdq_oe_o(fdq_oe_o)
);

// [bench/fcd_host_tb.sv]
`timescale 1ns/10ps
// flash host controller bench
module fcd_host_tb
    import fcd_pkg::*;
;
    localparam logic [15:0] ID_MFR = 16'h00a5; // arbitrary value
    localparam logic [15:0] ID_DEV = 16'h003c; // arbitrary value
    logic        mclk_i = 1'b0, rst_b_i = 1'b0, op_valid_i = 1'b0, dat_valid_i = 1'b0;
    fcd_op_t     op_i = FCD_OP_READ;
    logic [23:0] op_addr_i = '0, dat_addr_i = '0, faddr_o, ba = '0, a;
    logic [15:0] op_data_i = '0, dat_i = '0, rdata_o, fdq_o, mem_dq, seed = 16'h004e;
    logic [15:0] bw [16];
    logic [15:0] exp_mem [int];
    logic        op_ready_o, dat_req_o, done_o, abort_o, ce_b_o, we_b_o, oe_b_o, fdq_oe_o;
    logic [7:0]  bad_cnt, abort_cnt;
    int          miscompares = 0, num_checks = 0, bi = 0, bn = 0, aborts = 0;
    wire  [15:0] fdq_i = fdq_oe_o ? fdq_o : mem_dq; // wire level
    always #25 mclk_i = ~mclk_i;
    fcd_host u_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .op_addr_i(op_addr_i), .op_data_i(op_data_i), .byte_mode_i(1'b0),
        .op_ready_o(op_ready_o), .dat_req_o(dat_req_o), .dat_valid_i(dat_valid_i),
        .dat_addr_i(dat_addr_i), .dat_i(dat_i), .done_o(done_o), .abort_o(abort_o),
        .rdata_o(rdata_o), .ce_b_o(ce_b_o), .we_b_o(we_b_o), .oe_b_o(oe_b_o),
        .faddr_o(faddr_o), .fdq_o(fdq_o), .fdq_oe_o(fdq_oe_o), .fdq_i(fdq_i)
    );
    fcd_flash_model #(.ID_MFR(ID_MFR), .ID_DEV(ID_DEV)) u_mem (
        .mclk_i(mclk_i), .ce_b_i(ce_b_o), .we_b_i(we_b_o), .oe_b_i(oe_b_o), .addr_i(faddr_o),
        .dq_i(fdq_i), .program_enable_supply_hi_i(1'b1), .dq_o(mem_dq), .bad_o(bad_cnt), .abort_o(abort_cnt)
    );
    // next pseudo-random word
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one operation, ready to done
    task automatic op_run(input fcd_op_t o, input logic [23:0] ad, input logic [15:0] d);
        int n;
        n = 0;
        while (op_ready_o !== 1'b1 && n < 500) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        op_valid_i = 1'b1;
        op_i = o;
        op_addr_i = ad;
        op_data_i = d;
        @(posedge mclk_i);
        #2;
        op_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 500) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        if (n >= 500) miscompares++; // hang
    endtask
    // optional mode command, then one read
    task automatic rd(input fcd_op_t m, input logic [23:0] ad);
        if (m != FCD_OP_READ) op_run(m, ad, '0);
        op_run(FCD_OP_READ, ad, '0);
    endtask
    // poll status until ready
    task automatic poll();
        for (int i = 0; i < 30; i++) begin
            rd(FCD_OP_READ_STAT, '0);
            if (rdata_o[7] === 1'b1) break;
        end
    endtask
    // buffer word feed; aborts counted
    always @(posedge mclk_i) begin
        if (dat_valid_i && dat_req_o === 1'b1) bi++;
        if (abort_o === 1'b1) aborts++;
        #2;
        dat_valid_i = (bi < bn);
        dat_addr_i = ba + 24'(bi);
        dat_i = bw[bi[3:0]];
    end
    initial begin
        #2_000_000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        #2;
        rst_b_i = 1'b1;
        rd(FCD_OP_READ, 24'h01_0004);
        check(rdata_o, 16'hffff);
        rd(FCD_OP_READ_ID, 24'h00_0000);
        check(rdata_o, ID_MFR);
        rd(FCD_OP_READ, 24'h00_0001);
        check(rdata_o, ID_DEV);
        rd(FCD_OP_READ_QUERY, 24'h00_0010);
        check(rdata_o, 16'h0051);
        rd(FCD_OP_READ_ARRAY, 24'h00_0010);
        check(rdata_o, 16'hffff);
        // random programs in block 1
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = {8'h01, seed};
            seed = lfsr(seed);
            op_run(FCD_OP_PROG, a, seed);
            exp_mem[a] = seed;
            poll();
            rd(FCD_OP_READ_ARRAY, a);
            check(rdata_o, seed);
        end
        rd(FCD_OP_READ_STAT, '0);
        check(rdata_o, 16'h0080);
        // locked block refuses programs
        op_run(FCD_OP_LOCK_SET, 24'h02_0000, '0);
        poll();
        rd(FCD_OP_READ_ID, 24'h02_0002);
        check(rdata_o, 16'h0001);
        op_run(FCD_OP_PROG, 24'h02_0005, 16'h1234);
        poll();
        check(rdata_o, 16'h0092);
        op_run(FCD_OP_CLR_STAT, '0, '0);
        rd(FCD_OP_READ_STAT, '0);
        check(rdata_o, 16'h0080);
        op_run(FCD_OP_LOCK_CLR, '0, '0);
        poll();
        rd(FCD_OP_READ_ID, 24'h02_0002);
        check(rdata_o, 16'h0000);
        // erase with suspend and resume
        op_run(FCD_OP_ERASE, 24'h01_0000, '0);
        op_run(FCD_OP_SUSPEND, '0, '0);
        op_run(FCD_OP_RESUME, '0, '0);
        poll();
        foreach (exp_mem[k]) begin
            rd(FCD_OP_READ_ARRAY, 24'(k));
            check(rdata_o, 16'hffff);
        end
        // buffer programs: 1, 16, random words
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            bi = 0;
            bn = (i == 0) ? 1 : (i == 1) ? 16 : int'(seed[3:0]) + 1;
            ba = {8'h03 + 8'(i), seed[15:8], 8'h00};
            for (int j = 0; j < 16; j++) begin
                seed = lfsr(seed);
                bw[j] = seed;
            end
            op_run(FCD_OP_BUF_PROG, ba, 16'(bn - 1));
            poll();
            for (int j = 0; j <= bn; j++) begin
                rd(FCD_OP_READ_ARRAY, ba + 24'(j));
                check(rdata_o, (j < bn) ? bw[j] : 16'hffff);
            end
        end
        check(16'(bad_cnt), 16'h0000);
        check(16'(abort_cnt) + 16'(aborts), 16'h0000);
        wrap_up();
    end
endmodule

// [logic/fcd_bus_engine.sv]
`timescale 1ns/10ps
// drives one asynchronous write or read cycle on the flash pins
module fcd_bus_engine
    import fcd_pkg::*;
(
    input  wire logic  mclk_i,     // system clock
    input  wire logic  rst_b_i,    // async reset, low
    fcd_cyc_if.eng     cyc,        // cycle request
    output logic       ce_b_o,     // chip enable, low
    output logic       we_b_o,     // write strobe, low
    output logic       oe_b_o,     // output enable, low
    output logic [23:0] addr_o,    // address pins
    output logic [15:0] dq_o,      // data out
    output logic       dq_oe_o,    // data drive enable
    input  wire logic [15:0] dq_i  // data in, unsynchronised
);
    typedef enum logic [1:0] {FCD_E_IDLE, FCD_E_STROBE, FCD_E_REC} fcd_eng_st_t;
    fcd_eng_st_t  st_r, st_nxt;       // engine state
    logic [3:0]   cnt_r, cnt_nxt;     // phase counter
    logic         wr_r, wr_nxt;       // cycle direction
    logic [23:0]  adr_r, adr_nxt;     // held address
    logic [15:0]  wd_r, wd_nxt;       // held write data
    logic [15:0]  rd_r, rd_nxt;       // captured read data
    logic [15:0]  dq_s1_r, dq_s2_r;   // input synchroniser

    // data pins are asynchronous: two stages
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
        end else begin
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // next state: strobe, release, recovery
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        wr_nxt  = wr_r;
        adr_nxt = adr_r;
        wd_nxt  = wd_r;
        rd_nxt  = rd_r;
        case (st_r)
            FCD_E_IDLE: begin
                if (cyc.req) begin
                    st_nxt  = FCD_E_STROBE;
                    wr_nxt  = cyc.wr;
                    adr_nxt = cyc.addr;
                    wd_nxt  = cyc.wdata;
                    cnt_nxt = cyc.wr ? FCD_WE_CYC : FCD_RD_CYC + 4'h2;
                end
            end
            FCD_E_STROBE: begin
                // device latches on strobe rise
                if (cnt_r == 4'h1) begin
                    st_nxt  = FCD_E_REC;
                    cnt_nxt = FCD_REC_CYC;
                    if (!wr_r) rd_nxt = dq_s2_r;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            FCD_E_REC: begin
                if (cnt_r == 4'h1) st_nxt = FCD_E_IDLE;
                else cnt_nxt = cnt_r - 4'h1;
            end
            default: st_nxt = FCD_E_IDLE;
        endcase
    end

    // registers only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r  <= FCD_E_IDLE;
            cnt_r <= 4'h0;
            wr_r  <= 1'b0;
            adr_r <= 24'h00_0000;
            wd_r  <= 16'h0000;
            rd_r  <= 16'h0000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r  <= wr_nxt;
            adr_r <= adr_nxt;
            wd_r  <= wd_nxt;
            rd_r  <= rd_nxt;
        end
    end

    // pins; data held through recovery past the edge
    assign ce_b_o    = !(st_r == FCD_E_STROBE);
    assign we_b_o    = !(st_r == FCD_E_STROBE && wr_r);
    assign oe_b_o    = !(st_r == FCD_E_STROBE && !wr_r);
    assign addr_o    = adr_r;
    assign dq_o      = wd_r;
    assign dq_oe_o   = wr_r && (st_r != FCD_E_IDLE);
    assign cyc.done  = (st_r == FCD_E_REC) && (cnt_r == 4'h1);
    assign cyc.rdata = rd_r;
endmodule

// [logic/fcd_cyc_if.sv]
`timescale 1ns/10ps
// bus cycle request, sequencer to pin engine
interface fcd_cyc_if;
    import fcd_pkg::*;
    logic        req;      // start a cycle
    logic        wr;       // 1 write, 0 read
    logic [23:0] addr;     // cycle address
    logic [15:0] wdata;    // write data
    logic        done;     // cycle finished pulse
    logic [15:0] rdata;    // captured read data
    modport seq (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// [logic/fcd_host.sv]
`timescale 1ns/10ps
module fcd_host
    import fcd_pkg::*;
#(
    parameter int AW = 24,               // address width
    parameter int BUF_WORDS = 16         // buffer capacity in words (x16)
) (
    input  wire logic        mclk_i,      // system clock, 20 MHz
    input  wire logic        rst_b_i,     // async reset, low
    input  wire logic        op_valid_i,  // user operation request
    input  wire fcd_op_t     op_i,        // operation code
    input  wire logic [AW-1:0] op_addr_i, // target or block address
    input  wire logic [15:0] op_data_i,   // program data or count
    input  wire logic        byte_mode_i, // 1: x8 bus, 0: x16 bus
    output logic             op_ready_o,  // ready for a new operation
    output logic             dat_req_o,   // buffer data word wanted
    input  wire logic        dat_valid_i, // buffer data word present
    input  wire logic [AW-1:0] dat_addr_i, // buffer word address
    input  wire logic [15:0] dat_i,       // buffer word data
    output logic             done_o,      // operation finished pulse
    output logic             abort_o,     // buffer abort pulse, never raised
    output logic [15:0]      rdata_o,     // last read data
    output logic             ce_b_o,      // flash chip enable, low
    output logic             we_b_o,      // flash write strobe, low
    output logic             oe_b_o,      // flash output enable, low
    output logic [AW-1:0]    faddr_o,     // flash address
    output logic [15:0]      fdq_o,       // flash data out
    output logic             fdq_oe_o,    // flash data drive enable
    input  wire logic [15:0] fdq_i        // flash data in
);
    typedef enum logic [2:0] {
        FCD_S_IDLE, FCD_S_CMD, FCD_S_ARG, FCD_S_POLL, FCD_S_CNT, FCD_S_DATA, FCD_S_CONF
    } fcd_st_t;

    fcd_cyc_if cyc ();
    fcd_st_t     st_r, st_nxt;        // sequencer state
    fcd_op_t     op_r, op_nxt;        // operation in progress
    logic [AW-1:0] adr_r, adr_nxt;    // target address
    logic [15:0] arg_r, arg_nxt;      // second-cycle data or count
    logic [7:0]  left_r, left_nxt;    // buffer words remaining
    logic        req_r, req_nxt;      // cycle request pending
    logic        done_r, done_nxt;    // done pulse
    logic        abrt_r, abrt_nxt;    // abort pulse
    logic        bsy_r, bsy_nxt;      // data cycle in flight
    logic [15:0] rd_r, rd_nxt;        // read data register
    logic [23:0] eng_addr;            // zero-extended address
    logic [7:0]  cmax;                // count ceiling for bus width

    // command on low lane, upper zero
    function automatic logic [15:0] cmd_word(input logic [7:0] c);
        return {8'h00, c};
    endfunction

    // first command byte; defined codes only
    function automatic logic [7:0] first_cmd(input fcd_op_t o);
        case (o)
            FCD_OP_READ_ARRAY: return FCD_CMD_READ_ARRAY;
            FCD_OP_READ_ID:    return FCD_CMD_READ_ID;
            FCD_OP_READ_QUERY: return FCD_CMD_READ_QUERY;
            FCD_OP_READ_STAT:  return FCD_CMD_READ_STAT;
            FCD_OP_CLR_STAT:   return FCD_CMD_CLR_STAT;
            FCD_OP_PROG:       return FCD_CMD_PROG_A;
            FCD_OP_ERASE:      return FCD_CMD_ERASE;
            FCD_OP_SUSPEND:    return FCD_CMD_SUSPEND;
            FCD_OP_RESUME:     return FCD_CMD_CONFIRM;
            FCD_OP_LOCK_SET:   return FCD_CMD_LOCK_SETUP;
            FCD_OP_LOCK_CLR:   return FCD_CMD_LOCK_SETUP;
            FCD_OP_BUF_PROG:   return FCD_CMD_BUF_PROG;
            default:           return FCD_CMD_READ_ARRAY;
        endcase
    endfunction

    assign eng_addr = 24'(adr_r);
    assign cmax     = byte_mode_i ? FCD_MAX_CNT_BYTE : FCD_MAX_CNT_WORD;

    // sequencer next state
    always_comb begin
        st_nxt    = st_r;
        op_nxt    = op_r;
        adr_nxt   = adr_r;
        arg_nxt   = arg_r;
        left_nxt  = left_r;
        req_nxt   = 1'b0;
        done_nxt  = 1'b0;
        abrt_nxt  = 1'b0;
        bsy_nxt   = bsy_r;
        rd_nxt    = rd_r;
        cyc.wr    = 1'b1;
        cyc.wdata = cmd_word(first_cmd(op_r));
        case (st_r)
            FCD_S_IDLE: begin
                if (op_valid_i) begin
                    op_nxt  = op_i;
                    adr_nxt = op_addr_i;
                    arg_nxt = op_data_i;
                    req_nxt = 1'b1;
                    // plain read: no command, mode kept
                    st_nxt  = (op_i == FCD_OP_READ) ? FCD_S_ARG : FCD_S_CMD;
                end
            end
            FCD_S_CMD: begin
                if (cyc.done) begin
                    case (op_r)
                        FCD_OP_PROG, FCD_OP_ERASE, FCD_OP_LOCK_SET, FCD_OP_LOCK_CLR: begin
                            st_nxt  = FCD_S_ARG;
                            req_nxt = 1'b1;
                        end
                        FCD_OP_BUF_PROG: begin
                            st_nxt  = FCD_S_POLL;  // check buffer available
                            req_nxt = 1'b1;
                        end
                        default: begin
                            st_nxt   = FCD_S_IDLE;
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            FCD_S_ARG: begin
                cyc.wr = (op_r != FCD_OP_READ);
                case (op_r)
                    FCD_OP_PROG:     cyc.wdata = arg_r;
                    FCD_OP_ERASE:    cyc.wdata = cmd_word(FCD_CMD_CONFIRM);
                    FCD_OP_LOCK_SET: cyc.wdata = cmd_word(FCD_CMD_LOCK_SET);
                    default:         cyc.wdata = cmd_word(FCD_CMD_CONFIRM);
                endcase
                if (cyc.done) begin
                    if (op_r == FCD_OP_READ) rd_nxt = cyc.rdata;
                    st_nxt   = FCD_S_IDLE;
                    done_nxt = 1'b1;
                end
            end
            FCD_S_POLL: begin
                cyc.wr = 1'b0;
                if (cyc.done) begin
                    rd_nxt  = cyc.rdata;
                    req_nxt = 1'b1;
                    if (cyc.rdata[FCD_XSTAT_AVAIL]) st_nxt = FCD_S_CNT;
                    else                             st_nxt = FCD_S_CMD;  // reissue E8H
                end
            end
            FCD_S_CNT: begin
                // count clipped to the bus-width ceiling
                cyc.wdata = (arg_r[7:0] > cmax) ? {8'h00, cmax} : {8'h00, arg_r[7:0]};
                if (cyc.done) begin
                    left_nxt = cyc.wdata[7:0] + 8'h01;   // count plus one words
                    st_nxt   = FCD_S_DATA;
                end
            end
            FCD_S_DATA: begin
                cyc.wdata = arg_r;
                if (cyc.done) begin
                    left_nxt = left_r - 8'h01;
                    bsy_nxt  = 1'b0;
                    if (left_r == 8'h01) begin
                        st_nxt  = FCD_S_CONF;  // exactly count plus one, then confirm
                        req_nxt = 1'b1;
                    end
                end else if (!bsy_r && dat_valid_i) begin
                    adr_nxt = dat_addr_i;
                    arg_nxt = dat_i;
                    req_nxt = 1'b1;
                    bsy_nxt = 1'b1;
                end
            end
            FCD_S_CONF: begin
                cyc.wdata = cmd_word(FCD_CMD_CONFIRM);  // transfer starts only now
                if (cyc.done) begin
                    st_nxt   = FCD_S_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default: st_nxt = FCD_S_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r   <= FCD_S_IDLE;
            op_r   <= FCD_OP_READ_ARRAY;
            adr_r  <= '0;
            arg_r  <= 16'h0000;
            left_r <= 8'h00;
            req_r  <= 1'b0;
            done_r <= 1'b0;
            abrt_r <= 1'b0;
            bsy_r  <= 1'b0;
            rd_r   <= 16'h0000;
        end else begin
            st_r   <= st_nxt;
            op_r   <= op_nxt;
            adr_r  <= adr_nxt;
            arg_r  <= arg_nxt;
            left_r <= left_nxt;
            req_r  <= req_nxt;
            done_r <= done_nxt;
            abrt_r <= abrt_nxt;
            bsy_r  <= bsy_nxt;
            rd_r   <= rd_nxt;
        end
    end

    assign cyc.req  = req_r;
    assign cyc.addr = eng_addr;

    fcd_bus_engine u_eng (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .cyc     (cyc),
        .ce_b_o  (ce_b_o),
        .we_b_o  (we_b_o),
        .oe_b_o  (oe_b_o),
        .addr_o  (faddr_o),
        .dq_o    (fdq_o),
        .dq_oe_o (fdq_oe_o),
        .dq_i    (fdq_i)
    );

    assign op_ready_o = (st_r == FCD_S_IDLE);
    assign dat_req_o  = (st_r == FCD_S_DATA) && !bsy_r;
    assign done_o     = done_r;
    assign abort_o    = abrt_r;
    assign rdata_o    = rd_r;
endmodule

// [logic/fcd_pkg.sv]
package fcd_pkg;
    // command codes placed on the low data byte
    localparam logic [7:0] FCD_CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] FCD_CMD_READ_ID    = 8'h90;
    localparam logic [7:0] FCD_CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] FCD_CMD_READ_STAT  = 8'h70;
    localparam logic [7:0] FCD_CMD_CLR_STAT   = 8'h50;
    localparam logic [7:0] FCD_CMD_BUF_PROG   = 8'hE8;
    localparam logic [7:0] FCD_CMD_PROG_A     = 8'h40;
    localparam logic [7:0] FCD_CMD_PROG_B     = 8'h10;
    localparam logic [7:0] FCD_CMD_ERASE      = 8'h20;
    localparam logic [7:0] FCD_CMD_CONFIRM    = 8'hD0;
    localparam logic [7:0] FCD_CMD_SUSPEND    = 8'hB0;
    localparam logic [7:0] FCD_CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] FCD_CMD_LOCK_SET   = 8'h01;
    // buffer count limits
    localparam logic [7:0] FCD_MAX_CNT_BYTE   = 8'h1F;
    localparam logic [7:0] FCD_MAX_CNT_WORD   = 8'h0F;
    // extended status: buffer available bit
    localparam int         FCD_XSTAT_AVAIL    = 7;
    // bus timing in ns, cycles at 20 MHz
    localparam int         FCD_CLK_NS         = 50;
    localparam int         FCD_T_WE_LOW_NS    = 100;
    localparam int         FCD_T_RD_NS        = 150;
    localparam int         FCD_T_REC_NS       = 50;
    localparam logic [3:0] FCD_WE_CYC  = 4'((FCD_T_WE_LOW_NS + FCD_CLK_NS - 1) / FCD_CLK_NS);
    localparam logic [3:0] FCD_RD_CYC  = 4'((FCD_T_RD_NS + FCD_CLK_NS - 1) / FCD_CLK_NS);
    localparam logic [3:0] FCD_REC_CYC = 4'((FCD_T_REC_NS + FCD_CLK_NS - 1) / FCD_CLK_NS);
    // user operations
    typedef enum logic [3:0] {
        FCD_OP_READ_ARRAY, FCD_OP_READ_ID, FCD_OP_READ_QUERY, FCD_OP_READ_STAT,
        FCD_OP_CLR_STAT, FCD_OP_PROG, FCD_OP_ERASE, FCD_OP_SUSPEND, FCD_OP_RESUME,
        FCD_OP_LOCK_SET, FCD_OP_LOCK_CLR, FCD_OP_BUF_PROG, FCD_OP_READ
    } fcd_op_t;
endpackage
